// >>> logic/numeral_notify_pkg.sv
// constants and types for the numeral entry notifier
// Notes on behaviour
// - on completion of a numeric entry the strobe flag in the notify area is written as 1.
// - together with the strobe the changed entry index is written to the changed-entry word.
// - the changed entry index is written as three bcd digits, one nibble per digit.
// - once the strobe has been written as 1 it is written back to 0, one pulse per entry.
// - each entered value is written into the controller word allocated to its table entry.
// - the notify area may sit only in io, holding, auxiliary, link, data or extended memory.
// - link area words 00000 to 00199 are mapped to core io words 01000 to 01199.
// - extended memory is accepted only where supported, and never over serial, neither current nor bank.
// - control bits the controller writes into the control area change the device status.
package numeral_notify_pkg;

    // ------------------------------------------------------------
    // memory area codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        AREA_CORE_IO = 4'h0,
        AREA_HOLDING = 4'h1,
        AREA_AUX = 4'h2,
        AREA_LINK = 4'h3,
        AREA_TIMER_PV = 4'h4,
        AREA_TIMER_DONE = 4'h5,
        AREA_COUNTER_PV = 4'h6,
        AREA_COUNTER_DONE = 4'h7,
        AREA_WORK = 4'h8,
        AREA_TASK = 4'h9,
        AREA_DATA = 4'hA,
        AREA_EXT_CURRENT = 4'hB,
        AREA_EXT_BANK = 4'hC
    } area_t;

    localparam logic [15:0] LINK_MAP_FIRST = 16'h0000;
    localparam logic [15:0] LINK_MAP_LAST = 16'h00C7;
    localparam logic [15:0] LINK_MAP_BASE = 16'h03E8;
    localparam logic [15:0] STROBE_BIT_POS = 16'h000B;
    localparam logic [15:0] ENTRY_WORD_OFS = 16'h0001;
    localparam logic [9:0] ENTRY_MAX = 10'h3E7;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    // control bit positions in the control word
    localparam int CTRL_SCREEN_BIT = 15;
    localparam int CTRL_PRIO_BIT = 14;
    localparam int CTRL_BUZZ_CONT_BIT = 13;
    localparam int CTRL_BUZZ_INT_BIT = 12;
    localparam int CTRL_BLINK_BIT = 8;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        area_t area;
        logic [15:0] addr;
        logic [15:0] data;
    } mem_wr_t;

    typedef struct packed {
        logic screen_on;
        logic prio;
        logic buzz_cont;
        logic buzz_int;
        logic blink;
    } status_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_VALUE = 2'b01,
        ST_ENTRY = 2'b10,
        ST_CLEAR = 2'b11
    } phase_t;

    function automatic logic [11:0] to_bcd3(input logic [9:0] v);
        logic [9:0] h;
        logic [9:0] t;
        logic [9:0] r;
        h = v / 10'd100;
        r = v - h * 10'd100;
        t = r / 10'd10;
        r = r - t * 10'd10;
        return {h[3:0], t[3:0], r[3:0]};
    endfunction

endpackage

// >>> logic/numeral_entry_notifier.sv
// numeral entry notifier: writes value, entry index and strobe to controller memory
`timescale 1ns/1ns
module numeral_entry_notifier
    import numeral_notify_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // notify area placement
    input wire area_t notify_area_i,
    input wire logic [15:0] notify_addr_i,
    input wire logic ext_supported_i,
    input wire logic serial_proto_i,
    input wire logic aux_reserved_i,
    // operator entry
    input wire logic entry_done_i,
    input wire logic [9:0] entry_index_i,
    input wire area_t value_area_i,
    input wire logic [15:0] value_addr_i,
    input wire logic [15:0] entry_value_i,
    // controller memory write port
    output mem_wr_t mem_wr_o,
    input wire logic mem_ack_i,
    // control area word from controller
    input wire logic ctrl_valid_i,
    input wire logic [15:0] ctrl_word_i,
    // status
    output status_t status_o,
    output logic busy_o,
    output logic place_err_o
);

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    typedef struct packed {
        phase_t phase;
        mem_wr_t wr;
        logic [9:0] index;
        area_t varea;
        logic [15:0] vaddr;
        logic [15:0] value;
        area_t narea;
        logic [15:0] naddr;
        status_t status;
        logic err;
        logic busy;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // ------------------------------------------------------------
    // placement check
    // ------------------------------------------------------------
    // timer, counter, work and task words never take the notify area
    function automatic logic area_ok(input area_t a, input logic ext_ok, input logic serial,
                                     input logic aux_res);
        case (a)
            AREA_CORE_IO, AREA_HOLDING, AREA_LINK, AREA_DATA: area_ok = 1'b1;
            AREA_AUX: area_ok = !aux_res;
            AREA_EXT_CURRENT: area_ok = ext_ok && !serial;
            AREA_EXT_BANK: area_ok = ext_ok && !serial;
            default: area_ok = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // link-area translation
    // ------------------------------------------------------------
    // only the low link window moves; higher link words keep their area
    function automatic logic link_hit(input area_t a, input logic [15:0] addr);
        link_hit = (a == AREA_LINK) && (addr >= LINK_MAP_FIRST) && (addr <= LINK_MAP_LAST);
    endfunction

    // every write goes through here, value word and notify words alike
    function automatic mem_wr_t map_wr(input area_t a, input logic [15:0] addr,
                                       input logic [15:0] d);
        mem_wr_t w;
        w.valid = 1'b1;
        w.data = d;
        if (link_hit(a, addr)) begin
            w.area = AREA_CORE_IO;
            w.addr = addr + LINK_MAP_BASE;
        end else begin
            w.area = a;
            w.addr = addr;
        end
        return w;
    endfunction

    // ------------------------------------------------------------
    // notify words
    // ------------------------------------------------------------
    // indices past the table end are pinned to the last entry
    function automatic logic [9:0] clamp_index(input logic [9:0] ix);
        if (ix > ENTRY_MAX) begin
            clamp_index = ENTRY_MAX;
        end else begin
            clamp_index = ix;
        end
    endfunction

    // upper nibble stays zero, three bcd digits below it
    function automatic logic [15:0] entry_word(input logic [9:0] ix);
        entry_word = {4'h0, to_bcd3(ix)};
    endfunction

    // only the strobe bit is set, the rest of the word reads as zero
    function automatic logic [15:0] strobe_word();
        strobe_word = ZERO_WORD | (16'h0001 << STROBE_BIT_POS[3:0]);
    endfunction

    // ------------------------------------------------------------
    // control word decode
    // ------------------------------------------------------------
    // continuous buzzer masks the intermittent one; blink needs the screen on
    function automatic status_t ctrl_decode(input logic [15:0] w);
        status_t d;
        d.screen_on = w[CTRL_SCREEN_BIT];
        d.prio = w[CTRL_PRIO_BIT];
        d.buzz_cont = w[CTRL_BUZZ_CONT_BIT];
        d.buzz_int = w[CTRL_BUZZ_INT_BIT] && !w[CTRL_BUZZ_CONT_BIT];
        d.blink = w[CTRL_BLINK_BIT] && w[CTRL_SCREEN_BIT];
        return d;
    endfunction

    // ------------------------------------------------------------
    // reset state
    // ------------------------------------------------------------
    // screen starts lit, all else idle and zero
    function automatic state_t reset_state();
        state_t r;
        r = '0;
        r.phase = ST_IDLE;
        r.status.screen_on = 1'b1;
        return r;
    endfunction

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (ctrl_valid_i) begin
            s_nxt.status = ctrl_decode(ctrl_word_i);
        end
        case (s_r.phase)
            ST_IDLE: begin
                s_nxt.wr.valid = 1'b0;
                if (entry_done_i) begin
                    if (area_ok(notify_area_i, ext_supported_i, serial_proto_i,
                                aux_reserved_i)) begin
                        s_nxt.err = 1'b0;
                        s_nxt.index = clamp_index(entry_index_i);
                        s_nxt.varea = value_area_i;
                        s_nxt.vaddr = value_addr_i;
                        s_nxt.value = entry_value_i;
                        s_nxt.narea = notify_area_i;
                        s_nxt.naddr = notify_addr_i;
                        s_nxt.wr = map_wr(value_area_i, value_addr_i, entry_value_i);
                        s_nxt.phase = ST_VALUE;
                    end else begin
                        // refused placement: nothing is written
                        s_nxt.err = 1'b1;
                    end
                end
            end
            ST_VALUE: begin
                if (mem_ack_i) begin
                    // index word goes out before the strobe so it is valid at the edge
                    s_nxt.wr = map_wr(s_r.narea, s_r.naddr + ENTRY_WORD_OFS,
                                      entry_word(s_r.index));
                    s_nxt.phase = ST_ENTRY;
                end
            end
            ST_ENTRY: begin
                if (mem_ack_i) begin
                    s_nxt.wr = map_wr(s_r.narea, s_r.naddr, strobe_word());
                    s_nxt.phase = ST_CLEAR;
                end
            end
            ST_CLEAR: begin
                if (mem_ack_i) begin
                    // two writes here: the strobe word, then its clear
                    if (s_r.wr.data != ZERO_WORD) begin
                        s_nxt.wr = map_wr(s_r.narea, s_r.naddr, ZERO_WORD);
                    end else begin
                        s_nxt.wr.valid = 1'b0;
                        s_nxt.phase = ST_IDLE;
                    end
                end
            end
            default: begin
                s_nxt.phase = ST_IDLE;
            end
        endcase
        // busy kept in a flop so the port comes straight from a register
        s_nxt.busy = (s_nxt.phase != ST_IDLE);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_r <= reset_state();
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign mem_wr_o = s_r.wr;
    assign status_o = s_r.status;
    assign busy_o = s_r.busy;
    assign place_err_o = s_r.err;

endmodule

// >>> dv/numeral_entry_notifier_asserts.sv
// assertions on the ports of the numeral entry notifier
`timescale 1ns/1ns
module numeral_entry_notifier_asserts
    import numeral_notify_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic entry_done_i,
    input wire mem_wr_t mem_wr_o,
    input wire logic mem_ack_i,
    input wire logic ctrl_valid_i,
    input wire logic [15:0] ctrl_word_i,
    input wire status_t status_o,
    input wire logic busy_o,
    input wire logic place_err_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    logic [2:0] cnt_r;
    logic [15:0] sa_r;
    // counts accepted writes of the running sequence
    always_ff @(posedge clk_i) begin
        cnt_r <= (srst_i || !busy_o) ? 3'h0 : cnt_r + 3'(mem_wr_o.valid && mem_ack_i);
        if (mem_wr_o.valid && mem_ack_i && cnt_r == 3'h2) sa_r <= mem_wr_o.addr;
    end
    sequence s_ack(int n);
        mem_wr_o.valid && mem_ack_i && cnt_r == n;
    endsequence
    a_entry_taken: assert property (entry_done_i && !busy_o |=> busy_o || place_err_o)
        else $error("entry not taken");
    a_bcd_digits: assert property (mem_wr_o.valid && cnt_r == 3'h1 |->
        mem_wr_o.data[15:12] == 4'h0 && mem_wr_o.data[11:8] < 4'hA
        && mem_wr_o.data[7:4] < 4'hA && mem_wr_o.data[3:0] < 4'hA) else $error("bad bcd");
    a_strobe_word: assert property (mem_wr_o.valid && cnt_r == 3'h2 |->
        mem_wr_o.data == 16'h0800) else $error("bad strobe word");
    a_strobe_cleared: assert property (s_ack(2) |=> mem_wr_o.valid
        && mem_wr_o.data == 16'h0000 && mem_wr_o.addr == sa_r) else $error("strobe not cleared");
    a_run_ends: assert property (s_ack(3) |=> !busy_o && !mem_wr_o.valid)
        else $error("sequence too long");
    a_write_stands: assert property (mem_wr_o.valid && !mem_ack_i |=> $stable(mem_wr_o))
        else $error("write dropped");
    a_buzz_cont_wins: assert property (ctrl_valid_i && ctrl_word_i[13] |=>
        status_o.buzz_cont && !status_o.buzz_int) else $error("buzzer priority");
    a_blink_screen: assert property (ctrl_valid_i |=> status_o.blink ==
        ($past(ctrl_word_i[8]) && $past(ctrl_word_i[15]))) else $error("blink wrong");
endmodule
bind numeral_entry_notifier numeral_entry_notifier_asserts u_chk (.*);

// >>> dv/host_ctrl_model.sv
// host controller word memory answering notifier writes
`timescale 1ns/1ns
module host_ctrl_model
    import numeral_notify_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire mem_wr_t wr_i,
    input wire logic slow_i,
    input wire logic [19:0] skey_i,
    output logic ack_o,
    output logic seen_o,
    output logic [9:0] index_o
);
    logic [15:0] mem [logic [19:0]];
    logic [15:0] ew;
    logic [1:0] wait_r = 2'h0;
    logic stb_r = 1'b0;
    assign ack_o = wr_i.valid && (!slow_i || wait_r == 2'h3);
    always @(posedge clk_i) begin
        wait_r <= (srst_i || ack_o || !wr_i.valid) ? 2'h0 : wait_r + 2'h1;
        seen_o <= 1'b0;
        if (srst_i) stb_r <= 1'b0;
        if (ack_o) begin
            mem[{wr_i.area, wr_i.addr}] = wr_i.data;
            if ({wr_i.area, wr_i.addr} == skey_i) begin
                stb_r <= wr_i.data[11];
                // rising strobe: fetch the word after it
                if (wr_i.data[11] && !stb_r) begin
                    ew = mem[skey_i + 20'h1];
                    index_o <= 10'(ew[11:8] * 100 + ew[7:4] * 10 + ew[3:0]);
                    seen_o <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> dv/test_numeral_entry_notifier.sv
// self-checking bench for the numeral entry notifier
`timescale 1ns/1ns
module test_numeral_entry_notifier import numeral_notify_pkg::*; ();
    logic clk_i, srst_i = 1, done = 0, cv = 0, ext = 0, ser = 0, auxr = 0, slow = 0;
    logic ack, busy, perr, seen;
    area_t na = AREA_CORE_IO, va = AREA_CORE_IO;
    logic [15:0] naddr = 0, vaddr = 0, val = 0, cw = 0;
    logic [9:0] idx = 0, hidx;
    logic [19:0] skey = 0, vk;
    mem_wr_t wr;
    status_t st;
    mem_wr_t exp_q[$];
    int fails = 0, num_checks = 0, seed = 66016, cyc = 0, ci, nseen = 0;
    area_t vas[4] = '{AREA_CORE_IO, AREA_HOLDING, AREA_LINK, AREA_DATA};
    numeral_entry_notifier dut (.clk_i(clk_i), .srst_i(srst_i), .notify_area_i(na),
        .notify_addr_i(naddr), .ext_supported_i(ext), .serial_proto_i(ser),
        .aux_reserved_i(auxr), .entry_done_i(done), .entry_index_i(idx),
        .value_area_i(va), .value_addr_i(vaddr), .entry_value_i(val), .mem_wr_o(wr),
        .mem_ack_i(ack), .ctrl_valid_i(cv), .ctrl_word_i(cw), .status_o(st),
        .busy_o(busy), .place_err_o(perr));
    host_ctrl_model host (.clk_i(clk_i), .srst_i(srst_i), .wr_i(wr), .slow_i(slow),
        .skey_i(skey), .ack_o(ack), .seen_o(seen), .index_o(hidx));
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [19:0] mkey(area_t a, logic [15:0] ad);
        if (a == AREA_LINK && ad <= 16'h00C7) return {AREA_CORE_IO, ad + 16'h03E8};
        return {a, ad};
    endfunction
    function automatic bit legal(area_t a);
        case (a)
            AREA_CORE_IO, AREA_HOLDING, AREA_LINK, AREA_DATA: return 1;
            AREA_AUX: return !auxr;
            AREA_EXT_CURRENT, AREA_EXT_BANK: return ext && !ser;
            default: return 0;
        endcase
    endfunction
    task automatic entry(input area_t a, input logic [9:0] ix);
        bit ok;
        na = a;
        idx = ix;
        va = vas[$unsigned($random(seed)) % 4];
        naddr = 16'($random(seed)) & 16'h007F;
        vaddr = 16'h00C0 | (16'($random(seed)) & 16'h003F);
        val = 16'($random(seed));
        ok = legal(a);
        ci = (ix > 10'h3E7) ? 999 : int'(ix);
        skey = mkey(a, naddr);
        vk = mkey(va, vaddr);
        if (ok) begin
            exp_q.push_back({1'b1, vk, val});
            exp_q.push_back({1'b1, mkey(a, naddr + 16'h0001), 4'h0, 4'(ci / 100),
                4'(ci / 10 % 10), 4'(ci % 10)});
            exp_q.push_back({1'b1, skey, 16'h0800});
            exp_q.push_back({1'b1, skey, 16'h0000});
        end
        nseen = 0;
        done = 1;
        repeat (2) @(posedge clk_i);
        #1 done = 0;
        for (int i = 0; i < 99 && (busy || exp_q.size() > 0); i++) @(posedge clk_i);
        #1 check(perr, !ok);
        check(exp_q.size(), 0);
        if (ok) check(host.mem[vk], val);
        check(nseen, ok);
    endtask
    task automatic ctrl(input logic [15:0] w);
        cw = w;
        cv = 1;
        @(posedge clk_i) #1 cv = 0;
        check(st, {w[15], w[14], w[13], w[12] & ~w[13], w[8] & w[15]});
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
        if (wr.valid && ack) begin
            if (exp_q.size() == 0) check(1, 0);
            else check(wr, exp_q.pop_front());
        end
        if (seen) begin
            nseen++;
            check(hidx, 40'(ci));
        end
    end
    initial begin
        clk_i = 0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        repeat (8) @(posedge clk_i);
        #1 srst_i = 0;
        check({st, busy, perr, wr.valid}, 8'h80);
        for (int i = 0; i < 52; i++) begin
            {ext, ser, auxr, slow} = 4'($random(seed));
            entry(area_t'(i % 13), i == 0 ? 10'h3E7 : i == 1 ? 10'h3FF : 10'($random(seed)));
            ctrl(16'($random(seed)));
            $display("entry %0d done", i);
        end
        final_report();
    end
endmodule
